//--- logic/adcc_clkdiv.v
// converter clock divider: tick once per 2^sel system clocks
`timescale 1ns/100ps
`default_nettype none

module adcc_clkdiv
(
   input wire core_clk,
   input wire srst,
   input wire run,
   input wire [2:0] divSel,
   output wire tick
);

   reg [6:0] cnt_q;
   wire [6:0] divMask;

   assign divMask = 7'h7f >> (3'h7 - divSel);
   assign tick = run && ((cnt_q & divMask) == divMask);

   // the counter restarts with each run so the first tick is a full period
   always @(posedge core_clk)
   begin
      if (srst || !run)
      begin
         cnt_q <= 7'h00;
      end
      else
      begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

endmodule // adcc_clkdiv

`default_nettype wire

//--- logic/adcc_ctrl.v
// converter control: registers, start detect, SAR sequencer, interrupt
//
// Contract
// - start launches only after a full low, high, low pulse of the bit
// - busy flag reads 1 once a conversion has been launched
// - busy flag returns to 0 when the conversion finishes
// - completion sets interrupt flag; irq output only when enabled by mask
// - converter clock is system clock divided by 1 to 128, codes 000-111
// - converter powered only while enable is high; needed before converting
// - reference: 00 supply, 01 external pin, 10/11 amplifier output
// - external reference pin is disconnected whenever internal source chosen
// - amplifier input is external pin when select is 0, else bandgap
// - with both amplifier inputs apparently chosen, only bandgap is used
// - conversion is 4 sampling plus 12 converting clocks, 16 total
// - 12-bit result goes to high and low registers, aligned by format bit
// - result registers hold their contents while the converter is disabled
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_map.vh"

module adcc_ctrl
(
   input wire core_clk,
   input wire srst,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire compIn,
   output reg irq,
   output reg convPowerOn,
   output reg convBusy,
   output reg sampleActive,
   output reg [11:0] dacCode,
   output reg [3:0] channelSel,
   output reg [3:0] inputSel,
   output reg [1:0] refSelect,
   output reg refPinConnect,
   output reg ampEnable,
   output reg [1:0] ampGain,
   output reg ampInputBandgap,
   output reg ampInputPinConnect
);

   localparam ST_IDLE = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_CONVERT = 2'h2;

   reg [7:0] ctrl0_q;
   reg [7:0] ctrl1_q;
   reg [7:0] ctrl2_q;
   reg startArmed_q;
   reg [1:0] state_q;
   reg [3:0] step_q;
   reg [11:0] trial_q;
   reg [11:0] result_q;
   reg [7:0] istat_q;
   reg [7:0] imask_q;

   wire busReq;
   wire accept;
   wire wrAccept;
   wire convTick;
   wire convEn;
   wire fmtRight;
   wire startNew;
   wire launch;
   wire doneEvt;
   wire [7:0] wrByte;
   wire [11:0] bitSel;
   wire [11:0] keptTrial;
   wire [7:0] resHigh;
   wire [7:0] resLow;
   reg [31:0] readMux;

   assign busReq = avs_read || avs_write;
   // a request is taken at the edge where waitrequest is seen low
   assign accept = busReq && !avs_waitrequest;
   assign wrAccept = accept && avs_write;
   assign wrByte = avs_writedata[7:0];

   assign convEn = ctrl0_q[`ADCC_C0_EN];
   assign fmtRight = ctrl0_q[`ADCC_C0_FMT];
   assign startNew = wrByte[`ADCC_C0_START];

   // falling write of start after an armed rise, converter on and idle
   assign launch = wrAccept && (avs_address == `ADCC_OFS_CTRL0) &&
      startArmed_q && !startNew && convEn && (state_q == ST_IDLE);

   assign bitSel = 12'h800 >> step_q;
   // keep the trial bit when the input is at or above the trial level
   assign keptTrial = compIn ? trial_q : (trial_q & ~bitSel);
   assign doneEvt = (state_q == ST_CONVERT) && convTick &&
      (step_q == `ADCC_CONVERT_CYCLES - 4'h1);

   adcc_clkdiv u_clkdiv
   (
      .core_clk (core_clk),
      .srst (srst),
      .run (state_q != ST_IDLE),
      .divSel (ctrl1_q[`ADCC_C1_DIV_HI:`ADCC_C1_DIV_LO]),
      .tick (convTick)
   );

   // left format puts D[3:0] in the upper nibble of the low register
   assign resHigh = fmtRight ? {4'h0, result_q[11:8]} : result_q[11:4];
   assign resLow = fmtRight ? result_q[7:0] : {result_q[3:0], 4'h0};

   always @*
   begin
      readMux = 32'h00000000;
      case (avs_address)
         `ADCC_OFS_CTRL0:
         begin
            readMux[7:0] = ctrl0_q;
            readMux[`ADCC_C0_BUSY] = (state_q != ST_IDLE);
         end
         `ADCC_OFS_CTRL1: readMux[7:0] = ctrl1_q;
         `ADCC_OFS_CTRL2: readMux[7:0] = ctrl2_q;
         `ADCC_OFS_RESH: readMux[7:0] = resHigh;
         `ADCC_OFS_RESL: readMux[7:0] = resLow;
         `ADCC_OFS_ISTAT: readMux[7:0] = istat_q;
         `ADCC_OFS_IMASK: readMux[7:0] = imask_q;
         default: readMux = 32'h00000000;
      endcase
   end

   // one wait cycle per access keeps read data registered
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end
      else if (busReq && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? readMux : 32'h00000000;
      end
      else
      begin
         avs_waitrequest <= 1'b1;
      end
   end

   // control registers
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         ctrl0_q <= `ADCC_RESET_BYTE;
         ctrl1_q <= `ADCC_RESET_BYTE;
         ctrl2_q <= `ADCC_RESET_BYTE;
         imask_q <= `ADCC_RESET_BYTE;
         startArmed_q <= 1'b0;
      end
      else if (wrAccept)
      begin
         case (avs_address)
            `ADCC_OFS_CTRL0:
            begin
               ctrl0_q <= wrByte & `ADCC_C0_WMASK;
               // arm on a written one; any written zero ends the pulse
               startArmed_q <= startNew;
            end
            `ADCC_OFS_CTRL1: ctrl1_q <= wrByte & `ADCC_C1_WMASK;
            `ADCC_OFS_CTRL2: ctrl2_q <= wrByte & `ADCC_C2_WMASK;
            `ADCC_OFS_IMASK: imask_q <= wrByte & 8'h01;
            default: imask_q <= imask_q;
         endcase
      end
   end

   // conversion sequencer
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         state_q <= ST_IDLE;
         step_q <= 4'h0;
         trial_q <= 12'h000;
         result_q <= 12'h000;
         // the code moves with the trial, so a tick on every clock
         // already compares against the current trial
         dacCode <= 12'h000;
      end
      else if (!convEn)
      begin
         // powering down aborts; the result stays as it was
         state_q <= ST_IDLE;
         step_q <= 4'h0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (launch)
               begin
                  state_q <= ST_SAMPLE;
                  step_q <= 4'h0;
               end
            end
            ST_SAMPLE:
            begin
               if (convTick)
               begin
                  if (step_q == `ADCC_SAMPLE_CYCLES - 4'h1)
                  begin
                     state_q <= ST_CONVERT;
                     step_q <= 4'h0;
                     trial_q <= 12'h800;
                     dacCode <= 12'h800;
                  end
                  else
                  begin
                     step_q <= step_q + 4'h1;
                  end
               end
            end
            ST_CONVERT:
            begin
               if (convTick)
               begin
                  if (step_q == `ADCC_CONVERT_CYCLES - 4'h1)
                  begin
                     state_q <= ST_IDLE;
                     result_q <= keptTrial;
                     step_q <= 4'h0;
                  end
                  else
                  begin
                     trial_q <= keptTrial | (bitSel >> 1);
                     dacCode <= keptTrial | (bitSel >> 1);
                     step_q <= step_q + 4'h1;
                  end
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // sticky status: completion set wins over a write-one clear
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         istat_q <= `ADCC_RESET_BYTE;
      end
      else
      begin
         if (wrAccept && (avs_address == `ADCC_OFS_ISTAT))
         begin
            istat_q[`ADCC_IRQ_DONE] <= (istat_q[`ADCC_IRQ_DONE] &&
               !wrByte[`ADCC_IRQ_DONE]) || doneEvt;
         end
         else if (doneEvt)
         begin
            istat_q[`ADCC_IRQ_DONE] <= 1'b1;
         end
      end
   end

   // analog-facing controls, all registered
   always @(posedge core_clk)
   begin
      if (srst)
      begin
         irq <= 1'b0;
         convPowerOn <= 1'b0;
         convBusy <= 1'b0;
         sampleActive <= 1'b0;
         channelSel <= 4'h0;
         inputSel <= 4'h0;
         refSelect <= `ADCC_REF_SUPPLY;
         refPinConnect <= 1'b0;
         ampEnable <= 1'b0;
         ampGain <= 2'h0;
         ampInputBandgap <= 1'b0;
         ampInputPinConnect <= 1'b0;
      end
      else
      begin
         irq <= |(istat_q & imask_q);
         convPowerOn <= convEn;
         convBusy <= (state_q != ST_IDLE);
         sampleActive <= (state_q == ST_SAMPLE);
         channelSel <= ctrl0_q[`ADCC_C0_CH_HI:`ADCC_C0_CH_LO];
         inputSel <= ctrl1_q[`ADCC_C1_INS_HI:`ADCC_C1_INS_LO];
         refSelect <= ctrl2_q[`ADCC_C2_REF_HI:`ADCC_C2_REF_LO];
         // the pin is wired in only for the pin code; internal sources win
         refPinConnect <= (ctrl2_q[`ADCC_C2_REF_HI:`ADCC_C2_REF_LO] ==
            `ADCC_REF_PIN);
         ampEnable <= ctrl2_q[`ADCC_C2_AMPEN];
         ampGain <= ctrl2_q[`ADCC_C2_GAIN_HI:`ADCC_C2_GAIN_LO];
         ampInputBandgap <= ctrl2_q[`ADCC_C2_AMPIS];
         ampInputPinConnect <= !ctrl2_q[`ADCC_C2_AMPIS];
      end
   end

endmodule // adcc_ctrl

`default_nettype wire

//--- logic/adcc_map.vh
// register map, field positions and timing counts of the converter control
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// register byte offsets
`define ADCC_OFS_CTRL0 5'h00
`define ADCC_OFS_CTRL1 5'h04
`define ADCC_OFS_CTRL2 5'h08
`define ADCC_OFS_RESH 5'h0c
`define ADCC_OFS_RESL 5'h10
`define ADCC_OFS_ISTAT 5'h14
`define ADCC_OFS_IMASK 5'h18

// conv_control_reg0 fields
`define ADCC_C0_START 7
`define ADCC_C0_BUSY 6
`define ADCC_C0_EN 5
`define ADCC_C0_FMT 4
`define ADCC_C0_CH_HI 3
`define ADCC_C0_CH_LO 0

// conv_control_reg1 fields
`define ADCC_C1_INS_HI 7
`define ADCC_C1_INS_LO 4
`define ADCC_C1_DIV_HI 2
`define ADCC_C1_DIV_LO 0

// conv_control_reg2 fields
`define ADCC_C2_AMPEN 7
`define ADCC_C2_AMPIS 4
`define ADCC_C2_REF_HI 3
`define ADCC_C2_REF_LO 2
`define ADCC_C2_GAIN_HI 1
`define ADCC_C2_GAIN_LO 0

// writable bit masks, unimplemented bits read as zero
`define ADCC_C0_WMASK 8'hbf
`define ADCC_C1_WMASK 8'hf7
`define ADCC_C2_WMASK 8'h9f
`define ADCC_RESET_BYTE 8'h00

// reference select codes
`define ADCC_REF_SUPPLY 2'h0
`define ADCC_REF_PIN 2'h1

// interrupt status bit: conversion done
`define ADCC_IRQ_DONE 0

// conversion length in converter clock cycles
`define ADCC_SAMPLE_CYCLES 4'h4
`define ADCC_CONVERT_CYCLES 4'hc

`endif

//--- verif/adcc_comparator_model.sv
// analog comparator standing in for the converter front end
`timescale 1ns/100ps
`default_nettype none
module adcc_comparator_model
(
   input wire logic [11:0] dacCode,
   input wire logic [11:0] level,
   output logic compIn
);
   // ideal input: the search settles exactly on level
   assign compIn = level >= dacCode;
endmodule // adcc_comparator_model
`default_nettype wire

//--- verif/adcc_ctrl_props.sv
// port assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adcc_ctrl_props
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic convPowerOn,
   input wire logic convBusy,
   input wire logic sampleActive,
   input wire logic [1:0] refSelect,
   input wire logic refPinConnect,
   input wire logic ampInputBandgap,
   input wire logic ampInputPinConnect
);
   logic [15:0] busyCnt_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   // saturates so a stuck busy cannot wrap under the minimum
   always @(posedge core_clk)
      if (srst || !convBusy)
         busyCnt_q <= 16'h0;
      else if (busyCnt_q != 16'hffff)
         busyCnt_q <= busyCnt_q + 16'h1;
   property p_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("wait low twice");
   property p_ref; refPinConnect == (refSelect == 2'h1); endproperty
   a_ref: assert property (p_ref) else $error("ref pin");
   // outputs are still cleared on the first edge after reset
   property p_amp; !$past(srst) |-> ampInputBandgap != ampInputPinConnect;
   endproperty
   a_amp: assert property (p_amp) else $error("amp input");
   property p_go;
      $rose(convBusy) |-> $past(avs_write, 2) || $past(avs_write, 3);
   endproperty
   a_go: assert property (p_go) else $error("launch w/o write");
   property p_smp; $rose(convBusy) |-> ##[0:2] sampleActive; endproperty
   a_smp: assert property (p_smp) else $error("no sampling");
   property p_cnv; $fell(sampleActive) && convPowerOn |-> convBusy;
   endproperty
   a_cnv: assert property (p_cnv) else $error("no convert");
   property p_len; $fell(convBusy) && convPowerOn |-> busyCnt_q >= 16;
   endproperty
   a_len: assert property (p_len) else $error("too short");
   property p_off;
      $fell(convPowerOn) |-> ##[0:2] (!convBusy && !sampleActive);
   endproperty
   a_off: assert property (p_off) else $error("runs unpowered");
   c_done: cover property ($fell(convBusy) && convPowerOn);
   c_abort: cover property ($fell(convPowerOn) && convBusy);
   c_pin: cover property (refPinConnect);
endmodule // adcc_ctrl_props
bind adcc_ctrl adcc_ctrl_props i_props (.core_clk, .srst, .avs_write,
   .avs_waitrequest, .convPowerOn, .convBusy, .sampleActive, .refSelect,
   .refPinConnect, .ampInputBandgap, .ampInputPinConnect);
`default_nettype wire

//--- verif/test_adc_conversion_control.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module test_adc_conversion_control;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [4:0] avsAddress = 5'h00;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0;
   logic [11:0] level = 12'h000;
   logic [7:0] q;
   wire logic [31:0] avsReaddata;
   wire logic waitReq, compIn, irq, powerOn, busy, sampling;
   wire logic refPin, ampBg, ampPin;
   wire logic [11:0] dacCode;
   wire logic [1:0] refSel;
   wire logic ampEn;
   wire logic [3:0] chanSel, inSel;
   wire logic [1:0] gain;
   // settling wait after enabling the converter, length arbitrary
   localparam int SETTLE_CYCLES = 20;
   int numErrors = 0;
   int samplesChecked = 0;
   adcc_ctrl i_dut (.core_clk(core_clk), .srst(srst),
      .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
      .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
      .avs_waitrequest(waitReq), .compIn(compIn), .irq(irq),
      .convPowerOn(powerOn), .convBusy(busy), .sampleActive(sampling),
      .dacCode(dacCode), .channelSel(chanSel), .inputSel(inSel),
      .refSelect(refSel), .refPinConnect(refPin), .ampEnable(ampEn),
      .ampGain(gain),
      .ampInputBandgap(ampBg), .ampInputPinConnect(ampPin));
   adcc_comparator_model i_cmp (.dacCode(dacCode), .level(level),
      .compIn(compIn));
   task check(input logic [15:0] got, input logic [15:0] exp, string s);
      samplesChecked++;
      if (got !== exp)
      begin
         numErrors++;
         $display("unexpected at %0t: %s", $time, s);
      end
   endtask
   task bus(input logic [4:0] a, input logic w, input logic [7:0] d);
      int n;
      @(posedge core_clk);
      avsAddress <= a;
      avsWrite <= w;
      avsRead <= !w;
      avsWritedata <= {24'h0, d};
      n = 0;
      @(posedge core_clk);
      while (waitReq !== 1'b0 && n < 40)
      begin
         n++;
         @(posedge core_clk);
      end
      q = avsReaddata[7:0];
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      check(n < 40, 1, "bus hang");
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task rd(input logic [4:0] a, input logic [7:0] e, string s);
      bus(a, 1'b0, 8'h00);
      check(q, e, s);
   endtask
   task pulse(input logic [7:0] b);
      wr(5'h00, b);
      wr(5'h00, b | 8'h80);
      wr(5'h00, b);
   endtask
   task t_regs;
      logic [4:0] a;
      logic [2:0] r;
      for (a = 5'h00; a < 5'h1c; a += 5'h04)
         rd(a, 8'h00, "reset value");
      wr(5'h04, 8'hff);
      rd(5'h04, 8'hf7, "ctrl1 bits");
      wr(5'h04, 8'h00);
      wr(5'h08, 8'hff);
      rd(5'h08, 8'h9f, "ctrl2 bits");
      wr(5'h1c, 8'hff);
      rd(5'h1c, 8'h00, "unmapped");
      for (r = 3'h0; r < 3'h4; r++)
      begin
         wr(5'h00, {4'h0, r[1:0], ~r[1:0]});
         wr(5'h04, {~r[1:0], r[1:0], 4'h0});
         // pin-shared setup of the reference pin lives outside this block
         wr(5'h08, {r[1], 2'h0, r[0], r[1:0], ~r[1:0]});
         repeat (2) @(posedge core_clk);
         check(refPin, r == 3'h1, "ref pin");
         check(refSel, r[1:0], "ref select");
         check({ampBg, ampPin}, {r[0], !r[0]}, "amp input");
         check(ampEn, r[1], "amp enable");
         check(gain, {~r[1:0]}, "amp gain");
         check(chanSel, {r[1:0], ~r[1:0]}, "channel");
         check(inSel, {~r[1:0], r[1:0]}, "input select");
      end
   endtask
   task t_nostart;
      pulse(8'h00);
      repeat (40) @(posedge core_clk);
      check(busy, 0, "start while off");
      wr(5'h00, 8'h20);
      repeat (SETTLE_CYCLES) @(posedge core_clk);
      wr(5'h00, 8'ha0);
      repeat (40) @(posedge core_clk);
      check(busy, 0, "start held high");
      wr(5'h00, 8'h20);
      repeat (40) @(posedge core_clk);
      rd(5'h14, 8'h01, "late fall");
      wr(5'h14, 8'h01);
   endtask
   task t_conv(input logic [2:0] d, input logic f, input logic m);
      int n;
      logic [11:0] v;
      v = {9'h0, d} * 12'h249;
      level <= v;
      wr(5'h18, {7'h0, m});
      wr(5'h04, {5'h0, d});
      pulse({3'h1, f, 4'h0});
      for (n = 0; busy !== 1'b1 && n < 9; n++) @(posedge core_clk);
      for (n = 0; busy === 1'b1 && n < 3000; n++) @(posedge core_clk);
      check(n >= 16 << d && n <= (16 << d) + 3, 1, "length");
      rd(5'h14, 8'h01, "done flag");
      check(irq, m, "irq level");
      rd(5'h0c, f ? {4'h0, v[11:8]} : v[11:4], "result high");
      rd(5'h10, f ? v[7:0] : {v[3:0], 4'h0}, "result low");
      wr(5'h14, 8'h01);
      repeat (2) @(posedge core_clk);
      check(irq, 0, "irq clear");
   endtask
   task t_abort;
      level <= 12'h123;
      // a slow converter clock keeps its period in the accurate range
      wr(5'h04, 8'h05);
      pulse(8'h20);
      rd(5'h00, 8'h60, "busy bit");
      check(sampling, 1, "sampling");
      check(powerOn, 1, "power on");
      wr(5'h00, 8'h00);
      rd(5'h00, 8'h00, "aborted");
      repeat (8) @(posedge core_clk);
      check({powerOn, busy, sampling}, 0, "still running");
      rd(5'h14, 8'h00, "no done");
      rd(5'h0c, 8'hff, "kept high");
      rd(5'h10, 8'hf0, "kept low");
   endtask
   task completeRun;
      $display("errors %0d checks %0d", numErrors, samplesChecked);
      if (numErrors == 0 && samplesChecked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial forever #10 core_clk = ~core_clk;
   initial
   begin
      repeat (60000) @(posedge core_clk);
      numErrors++;
      completeRun;
   end
   initial
   begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      t_regs;
      t_nostart;
      for (int d = 0; d < 8; d++)
         t_conv(d[2:0], d[0], d != 3);
      t_abort;
      completeRun;
   end
endmodule // test_adc_conversion_control
`default_nettype wire
